//--- scc_cfg.svh
// Register offsets, field positions, reset values and gain and pixel constants for the sensor control bank
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_ADDR_RESET      8'h0E
`define SCC_ADDR_GAIN       8'h10
`define SCC_ADDR_TRISTATE   8'h12
`define SCC_ADDR_BASE_OFS   8'h20
`define SCC_ADDR_OFS_CTRL   8'h21
`define SCC_ADDR_FINAL_OFS  8'h23
`define SCC_ADDR_COLPOS0    8'h24
`define SCC_ADDR_TABLE0     8'h28
`define SCC_ADDR_CAPTURE    8'h40
`define SCC_RST_RESET       8'h00
`define SCC_RST_GAIN        8'h08
`define SCC_RST_TRISTATE    8'hC0
`define SCC_RST_BASE_OFS    8'h00
`define SCC_RST_OFS_CTRL    8'h00
`define SCC_RST_FINAL_OFS   8'h00
`define SCC_RST_TABLE       8'h00
`define SCC_RST_CAPTURE     8'hAA
`define SCC_BIT_STATE_RST   1
`define SCC_BIT_PROG_RST    0
`define SCC_BIT_CLK_EN      7
`define SCC_BIT_DATA_EN     6
`define SCC_BIT_SIGN6       5
`define SCC_BIT_SIGN4       3
`define SCC_BIT_SHUTTER     7
`define SCC_BIT_HALT        6
`define SCC_BIT_FS_POL      5
`define SCC_BIT_ROW_SCOPE   4
`define SCC_BIT_ROW_POL     3
`define SCC_BIT_WORD_SCOPE  2
`define SCC_BIT_WORD_POL    1
`define SCC_BIT_CLAMP       0
`define SCC_BIT_COL_EN      0
`define SCC_GAIN_BASE       16'd67
`define SCC_GAIN_STEP       16'd8
`define SCC_GAIN_DIV        16'd100
`define SCC_PIX_MAX         10'd255
`define SCC_ENTRIES         4
`define SCC_COL_MASK        6'h3F
`define SCC_CLAMP_STEP      8'h01
`endif

//--- scc_pkg.sv
// Types shared by the sensor control bank
package scc_pkg;
  typedef enum logic [1:0] {
    SCC_CAP_IDLE,
    SCC_CAP_FRAME,
    SCC_CAP_HALTED
  } scc_cap_type;
  typedef logic [7:0] scc_byte_type;
endpackage : scc_pkg

//--- scc_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module scc_sync (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_r;
  // First stage feeds only the second
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta_r <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule : scc_sync

//--- scc_pixel_math.sv
// Pixel arithmetic: offsets then global gain, saturated to 8 bits
`timescale 1ns/1ns
`include "scc_cfg.svh"
module scc_pixel_math (
  input  wire logic [7:0] pix_in,
  input  wire logic [5:0] base_ofs_in,
  input  wire logic       col_en_in,
  input  wire logic [3:0] col_entry_in,
  input  wire logic       col_hit_in,
  input  wire logic [5:0] final_ofs_in,
  input  wire logic [5:0] gain_in,
  output logic      [7:0] pix_out
);
  // Signed magnitude to signed value, sign set means subtract
  function automatic logic signed [11:0] sm_val(input logic neg, input logic [5:0] mag);
    sm_val = neg ? -$signed({6'h00, mag}) : $signed({6'h00, mag});
  endfunction : sm_val
  function automatic logic [7:0] sat8(input logic signed [11:0] v);
    if (v < 0) sat8 = 8'h00;
    else if (v > $signed({2'b00, `SCC_PIX_MAX})) sat8 = 8'hFF;
    else sat8 = v[7:0];
  endfunction : sat8
  logic signed [11:0] ofs_sum;
  logic [7:0]         pre_gain;
  logic [23:0]        gained;
  // Base and column offsets doubled, final offset one code per step
  always_comb begin
    ofs_sum = $signed({4'h0, pix_in})
            + sm_val(base_ofs_in[`SCC_BIT_SIGN6], {base_ofs_in[4:0], 1'b0});
    if (col_en_in && col_hit_in)
      ofs_sum = ofs_sum + sm_val(col_entry_in[`SCC_BIT_SIGN4],
                                 {2'b00, col_entry_in[2:0], 1'b0});
    ofs_sum = ofs_sum + sm_val(final_ofs_in[`SCC_BIT_SIGN6],
                               {1'b0, final_ofs_in[4:0]});
    pre_gain = sat8(ofs_sum);
    // Gain in hundredths: 67 + 8*code; 24 bits so 255 * 571 cannot wrap
    gained = (24'(pre_gain) * (24'(`SCC_GAIN_BASE) + 24'(`SCC_GAIN_STEP) * 24'(gain_in)))
             / 24'(`SCC_GAIN_DIV);
    pix_out = (gained > 24'(`SCC_PIX_MAX)) ? 8'hFF : gained[7:0];
  end
endmodule : scc_pixel_math

//--- scc_sensor_ctrl.sv
// Sensor control register bank with offset, gain and output strobe shaping
`timescale 1ns/1ns
`include "scc_cfg.svh"
module scc_sensor_ctrl (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire scc_pkg::scc_byte_type reg_wdata_in,
  output scc_pkg::scc_byte_type      reg_rdata_out,
  input  wire logic                  frame_trigger_in,
  input  wire logic                  frame_start_in,
  input  wire logic                  frame_end_in,
  input  wire logic                  row_start_in,
  input  wire logic                  row_in_window_in,
  input  wire logic                  pix_valid_in,
  input  wire logic                  pix_in_window_in,
  input  wire logic [5:0]            pix_col_in,
  input  wire logic [7:0]            pix_in,
  input  wire logic [7:0]            dark_level_in,
  output logic [7:0]                 pix_data_out,
  output logic                       pix_data_oe_out,
  output logic                       clk_out_oe_out,
  output logic                       frame_start_out,
  output logic                       row_clock_out,
  output logic                       word_clock_out,
  output logic [7:0]                 dark_clamp_out,
  output logic                       frame_active_out
);
  import scc_pkg::*;

  // Programmable registers
  scc_byte_type reset_ctrl_r;
  scc_byte_type gain_r;
  scc_byte_type tristate_r;
  scc_byte_type base_ofs_r;
  scc_byte_type ofs_ctrl_r;
  scc_byte_type final_ofs_r;
  scc_byte_type colpos_r [`SCC_ENTRIES];
  scc_byte_type table_r  [`SCC_ENTRIES];
  scc_byte_type capture_r;

  // Non-programmable state
  scc_cap_type  cap_state_r;
  scc_cap_type  cap_state_nxt;
  logic [7:0]   clamp_r;
  logic         trig_sync;
  logic         trig_d_r;
  logic         trig_pend_r;
  logic [7:0]   pix_math;
  logic [3:0]   col_entry;
  logic         col_hit;
  logic         prog_rst;
  logic         state_rst;

  // Reset bits hold their block in reset for as long as they stay set
  assign prog_rst  = rst_in | reset_ctrl_r[`SCC_BIT_PROG_RST];
  assign state_rst = rst_in | reset_ctrl_r[`SCC_BIT_STATE_RST];

  // Trigger pin arrives from the host, synchronised first
  scc_sync u_trig_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    (frame_trigger_in),
    .q_out   (trig_sync)
  );

  // Which register is addressed as a table or position entry
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] b);
    in_range = (a >= b) && (a < b + 8'(`SCC_ENTRIES));
  endfunction : in_range

  // Reset control is its own register so it can release itself
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      reset_ctrl_r <= `SCC_RST_RESET;
    end else if (reg_wr_in && reg_addr_in == `SCC_ADDR_RESET) begin
      reset_ctrl_r <= reg_wdata_in;
    end
  end

  // Programmable register writes; bit 0 reset touches only these
  always_ff @(posedge mclk_in) begin
    if (prog_rst) begin
      gain_r      <= `SCC_RST_GAIN;
      tristate_r  <= `SCC_RST_TRISTATE;
      base_ofs_r  <= `SCC_RST_BASE_OFS;
      ofs_ctrl_r  <= `SCC_RST_OFS_CTRL;
      final_ofs_r <= `SCC_RST_FINAL_OFS;
      capture_r   <= `SCC_RST_CAPTURE;
      for (int i = 0; i < `SCC_ENTRIES; i++) begin
        colpos_r[i] <= `SCC_RST_TABLE;
        table_r[i]  <= `SCC_RST_TABLE;
      end
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `SCC_ADDR_GAIN:      gain_r      <= {2'b00, reg_wdata_in[5:0]};
        `SCC_ADDR_TRISTATE:  tristate_r  <= {reg_wdata_in[7:6], 6'h00};
        `SCC_ADDR_BASE_OFS:  base_ofs_r  <= {2'b00, reg_wdata_in[5:0]};
        `SCC_ADDR_OFS_CTRL:  ofs_ctrl_r  <= {7'h00, reg_wdata_in[0]};
        `SCC_ADDR_FINAL_OFS: final_ofs_r <= {2'b00, reg_wdata_in[5:0]};
        `SCC_ADDR_CAPTURE:   capture_r   <= reg_wdata_in;
        default: begin
          for (int i = 0; i < `SCC_ENTRIES; i++) begin
            if (reg_addr_in == `SCC_ADDR_COLPOS0 + 8'(i))
              colpos_r[i] <= {2'b00, reg_wdata_in[5:0]};
            if (reg_addr_in == `SCC_ADDR_TABLE0 + 8'(i))
              table_r[i] <= {4'h0, reg_wdata_in[3:0]};
          end
        end
      endcase
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `SCC_ADDR_RESET:     reg_rdata_out <= reset_ctrl_r;
        `SCC_ADDR_GAIN:      reg_rdata_out <= gain_r;
        `SCC_ADDR_TRISTATE:  reg_rdata_out <= tristate_r;
        `SCC_ADDR_BASE_OFS:  reg_rdata_out <= base_ofs_r;
        `SCC_ADDR_OFS_CTRL:  reg_rdata_out <= ofs_ctrl_r;
        `SCC_ADDR_FINAL_OFS: reg_rdata_out <= final_ofs_r;
        `SCC_ADDR_CAPTURE:   reg_rdata_out <= capture_r;
        default: begin
          reg_rdata_out <= 8'h00;
          if (in_range(reg_addr_in, `SCC_ADDR_COLPOS0))
            reg_rdata_out <= colpos_r[reg_addr_in[1:0]];
          if (in_range(reg_addr_in, `SCC_ADDR_TABLE0))
            reg_rdata_out <= table_r[reg_addr_in[1:0]];
        end
      endcase
    end
  end

  // Column match within the repeating 64-column group; lowest entry wins
  always_comb begin
    col_hit   = 1'b0;
    col_entry = 4'h0;
    for (int i = `SCC_ENTRIES - 1; i >= 0; i--) begin
      if ((pix_col_in & `SCC_COL_MASK) == colpos_r[i][5:0]) begin
        col_hit   = 1'b1;
        col_entry = table_r[i][3:0];
      end
    end
  end

  scc_pixel_math u_math (
    .pix_in       (pix_in),
    .base_ofs_in  (base_ofs_r[5:0]),
    .col_en_in    (ofs_ctrl_r[`SCC_BIT_COL_EN]),
    .col_entry_in (col_entry),
    .col_hit_in   (col_hit),
    .final_ofs_in (final_ofs_r[5:0]),
    .gain_in      (gain_r[5:0]),
    .pix_out      (pix_math)
  );

  // Trigger edge is remembered until a halted stream can use it
  always_ff @(posedge mclk_in) begin
    if (state_rst) begin
      trig_d_r    <= 1'b0;
      trig_pend_r <= 1'b0;
    end else begin
      trig_d_r <= trig_sync;
      if (trig_sync && !trig_d_r)
        trig_pend_r <= 1'b1;
      else if (cap_state_r == SCC_CAP_HALTED && trig_pend_r && frame_start_in)
        trig_pend_r <= 1'b0;
    end
  end

  // Frame gating: which frames are passed out to the host
  always_comb begin
    cap_state_nxt = cap_state_r;
    case (cap_state_r)
      SCC_CAP_IDLE: begin
        // Single capture or a pending halt lets no untriggered frame through
        if (capture_r[`SCC_BIT_SHUTTER] || capture_r[`SCC_BIT_HALT])
          cap_state_nxt = SCC_CAP_HALTED;
        else if (frame_start_in)
          cap_state_nxt = SCC_CAP_FRAME;
      end
      SCC_CAP_FRAME: begin
        if (frame_end_in) begin
          // Single capture stops after one frame; halt waits for frame end
          if (capture_r[`SCC_BIT_SHUTTER] || capture_r[`SCC_BIT_HALT])
            cap_state_nxt = SCC_CAP_HALTED;
          else
            cap_state_nxt = SCC_CAP_IDLE;
        end
      end
      SCC_CAP_HALTED: begin
        if (!capture_r[`SCC_BIT_SHUTTER] && !capture_r[`SCC_BIT_HALT])
          cap_state_nxt = SCC_CAP_IDLE;
        else if (trig_pend_r && frame_start_in)
          cap_state_nxt = SCC_CAP_FRAME;
      end
      default: cap_state_nxt = SCC_CAP_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (state_rst) begin
      cap_state_r <= SCC_CAP_IDLE;
    end else begin
      cap_state_r <= cap_state_nxt;
    end
  end

  // Dark clamp tracks the dark level one step per frame while enabled
  always_ff @(posedge mclk_in) begin
    if (state_rst) begin
      clamp_r <= 8'h00;
    end else if (capture_r[`SCC_BIT_CLAMP] && frame_start_in) begin
      if (clamp_r < dark_level_in)
        clamp_r <= clamp_r + `SCC_CLAMP_STEP;
      else if (clamp_r > dark_level_in)
        clamp_r <= clamp_r - `SCC_CLAMP_STEP;
    end
  end

  // Output strobes and data, all registered; polarity applied by XNOR
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pix_data_out     <= 8'h00;
      pix_data_oe_out  <= 1'b0;
      clk_out_oe_out   <= 1'b0;
      frame_start_out  <= 1'b0;
      row_clock_out    <= 1'b0;
      word_clock_out   <= 1'b0;
      dark_clamp_out   <= 8'h00;
      frame_active_out <= 1'b0;
    end else begin
      pix_data_oe_out  <= tristate_r[`SCC_BIT_DATA_EN];
      clk_out_oe_out   <= tristate_r[`SCC_BIT_CLK_EN];
      dark_clamp_out   <= clamp_r;
      frame_active_out <= (cap_state_nxt == SCC_CAP_FRAME);
      if (pix_valid_in && pix_in_window_in)
        pix_data_out <= pix_math;
      frame_start_out <= ~((frame_start_in && cap_state_nxt == SCC_CAP_FRAME)
                           ^ capture_r[`SCC_BIT_FS_POL]);
      row_clock_out <= ~((row_start_in && cap_state_r == SCC_CAP_FRAME
                          && (row_in_window_in || capture_r[`SCC_BIT_ROW_SCOPE]))
                         ^ capture_r[`SCC_BIT_ROW_POL]);
      word_clock_out <= ~((pix_valid_in && cap_state_r == SCC_CAP_FRAME
                           && (pix_in_window_in || capture_r[`SCC_BIT_WORD_SCOPE]))
                          ^ capture_r[`SCC_BIT_WORD_POL]);
    end
  end
endmodule : scc_sensor_ctrl

//--- scc_sensor_ctrl_asserts.sv
// Checker for the sensor control bank ports
`timescale 1ns/1ns
`include "scc_cfg.svh"
module scc_chk (
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       frame_start_in,
  input wire logic       frame_end_in,
  input wire logic       row_start_in,
  input wire logic       row_in_window_in,
  input wire logic       pix_valid_in,
  input wire logic       pix_in_window_in,
  input wire logic       pix_data_oe_out,
  input wire logic       clk_out_oe_out,
  input wire logic       frame_start_out,
  input wire logic       row_clock_out,
  input wire logic       word_clock_out,
  input wire logic [7:0] dark_clamp_out,
  input wire logic       frame_active_out
);
  import scc_pkg::*;
  logic [7:0] cap_r;
  logic [7:0] tri_r;
  logic [1:0] rc_r;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // Shadow registers; a held bank reads back its reset values
  always_ff @(posedge mclk_in) begin
    if (rst_in || rc_r[0]) begin
      cap_r <= `SCC_RST_CAPTURE;
      tri_r <= `SCC_RST_TRISTATE;
    end else if (reg_wr_in && reg_addr_in == `SCC_ADDR_CAPTURE) begin
      cap_r <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == `SCC_ADDR_TRISTATE) begin
      tri_r <= reg_wdata_in;
    end
  end
  // Shadow of the block reset bits, used to mute checks while state is held
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rc_r <= 2'h0;
    end else if (reg_wr_in && reg_addr_in == `SCC_ADDR_RESET) begin
      rc_r <= reg_wdata_in[1:0];
    end
  end
  a_oe_follow: assert property (reg_wr_in && !rc_r[0] && reg_addr_in == `SCC_ADDR_TRISTATE |=>
    ##[0:2] pix_data_oe_out == tri_r[6] && clk_out_oe_out == tri_r[7]) else $error("oe wrong");
  a_frame_stop: assert property (frame_active_out && frame_end_in |=> !frame_active_out)
    else $error("frame did not stop");
  a_frame_cause: assert property ($rose(frame_active_out) |-> $past(frame_start_in))
    else $error("frame without start");
  a_sof_level: assert property ($rose(frame_active_out) |-> frame_start_out == cap_r[5])
    else $error("frame start level wrong");
  a_row_clock: assert property (frame_active_out && row_start_in |=>
    row_clock_out == ($past(row_in_window_in || cap_r[4]) ? cap_r[3] : !cap_r[3]))
    else $error("row clock wrong");
  a_word_clock: assert property (frame_active_out && pix_valid_in &&
    (pix_in_window_in || !cap_r[2]) |=>
    word_clock_out == ($past(pix_in_window_in) ? cap_r[1] : !cap_r[1])) else $error("word clock");
  a_clamp_hold: assert property (!frame_start_in && !$past(frame_start_in) && !reg_wr_in &&
    rc_r == 2'h0 |=>
    $stable(dark_clamp_out)) else $error("clamp moved");
  a_clamp_step: assert property (frame_start_in |=>
    dark_clamp_out - $past(dark_clamp_out) inside {8'h00, 8'h01, 8'hFF}) else $error("clamp jump");
  c_halted_frame: cover property (cap_r[6] && $rose(frame_active_out));
  c_row_all: cover property (frame_active_out && row_start_in && !row_in_window_in && cap_r[4]);
  c_clamp: cover property (frame_start_in && cap_r[0]);
endmodule : scc_chk
bind scc_sensor_ctrl scc_chk scc_chk_inst (.*);

//--- scc_host_model.sv
// Host model: drives the frame trigger pin from its own clock and counts frames
`timescale 1ns/1ns
module scc_host_model (
  input  wire logic mclk_in,
  input  wire logic fire_in,
  input  wire logic frame_active_in,
  output logic      frame_trigger_out,
  output int        frames_out
);
  logic host_clk;
  logic act_r;
  // Host clock edges fall on master clock falling edges, never on its rising edges
  initial begin
    host_clk = 1'b0;
    frame_trigger_out = 1'b0;
    frames_out = 0;
    forever #40 host_clk = ~host_clk;
  end
  // Pin held a whole host period or more so the sensor's sync always sees it
  always @(posedge host_clk) begin
    frame_trigger_out <= fire_in;
  end
  // Count frames as they start
  always @(posedge mclk_in) begin
    act_r <= frame_active_in;
    if (frame_active_in && !act_r) begin
      frames_out <= frames_out + 1;
    end
  end
endmodule : scc_host_model

//--- scc_sensor_ctrl_tb.sv
// Self-checking bench for the sensor control bank
`timescale 1ns/1ns
`include "scc_cfg.svh"
module scc_sensor_ctrl_tb;
  import scc_pkg::*;
  logic       mclk_in, rst_in, reg_wr_in, reg_rd_in, frame_trigger_in, frame_start_in, fire;
  logic       frame_end_in, row_start_in, row_in_window_in, pix_valid_in, pix_in_window_in;
  logic       pix_data_oe_out, clk_out_oe_out, frame_start_out, row_clock_out, word_clock_out;
  logic       frame_active_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, pix_in, dark_level_in, pix_data_out;
  logic [7:0] dark_clamp_out, cap;
  logic [5:0] pix_col_in;
  int         frames, error_cnt, checks_done;
  scc_sensor_ctrl scc_sensor_ctrl_inst (.*);
  scc_host_model scc_host_model_inst (.mclk_in(mclk_in), .fire_in(fire),
    .frame_active_in(frame_active_out), .frame_trigger_out(frame_trigger_in), .frames_out(frames));
  // Master clock
  always #2 mclk_in = ~mclk_in;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
    checks_done++;
    if (seen !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    {reg_wr_in, reg_addr_in, reg_wdata_in} = {1'b1, a, d};
    tick(1);
    reg_wr_in = 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    tick(1);
    {reg_rd_in, reg_addr_in} = {1'b1, a};
    tick(1);
    reg_rd_in = 1'b0;
    tick(1);
    chk("reg", reg_rdata_out, e);
  endtask : rdc
  task automatic wcap(input logic [7:0] d);
    cap = d;
    wr(`SCC_ADDR_CAPTURE, d);
  endtask : wcap
  task automatic px(input logic [5:0] c, input logic [7:0] p, input logic [7:0] e);
    tick(1);
    {pix_valid_in, pix_in_window_in, pix_col_in, pix_in} = {2'h3, c, p};
    tick(1);
    {pix_valid_in, pix_in_window_in} = 2'h0;
    tick(1);
    chk("pix", pix_data_out, e);
  endtask : px
  // Frame start, then one row and one pixel outside the window
  task automatic fstart(input logic e);
    tick(1);
    frame_start_in = 1'b1;
    tick(1);
    frame_start_in = 1'b0;
    chk("active", frame_active_out, e);
    if (e) begin
      chk("sof", frame_start_out, cap[5]);
      {row_start_in, pix_valid_in} = 2'h3;
      tick(1);
      {row_start_in, pix_valid_in} = 2'h0;
      chk("row", row_clock_out, cap[4] ? cap[3] : !cap[3]);
      chk("word", word_clock_out, cap[2] ? cap[1] : !cap[1]);
    end
  endtask : fstart
  task automatic fend();
    tick(1);
    frame_end_in = 1'b1;
    tick(1);
    frame_end_in = 1'b0;
    tick(1);
    chk("idle", frame_active_out, 8'h00);
  endtask : fend
  task automatic frame(input logic e);
    fstart(e);
    fend();
  endtask : frame
  task automatic trig();
    fire = 1'b1;
    tick(30);
    fire = 1'b0;
    tick(30);
  endtask : trig
  task automatic t_regs();
    logic [15:0] t [9] = '{16'h0E00, 16'h1008, 16'h12C0, 16'h2000, 16'h2100, 16'h2300,
                           16'h2800, 16'h40AA, 16'h3000};
    foreach (t[i]) rdc(t[i][15:8], t[i][7:0]);
    chk("oe", {pix_data_oe_out, clk_out_oe_out}, 8'h03);
    $display("reset values done");
  endtask : t_regs
  task automatic t_mask();
    logic [15:0] t [8] = '{16'h103F, 16'h12C0, 16'h203F, 16'h2101, 16'h233F, 16'h280F,
                           16'h40FF, 16'h3000};
    foreach (t[i]) begin
      wr(t[i][15:8], 8'hFF);
      rdc(t[i][15:8], t[i][7:0]);
    end
    wr(`SCC_ADDR_RESET, 8'h01);
    wr(`SCC_ADDR_RESET, 8'h00);
    rdc(`SCC_ADDR_CAPTURE, 8'hAA);
    $display("field widths done");
  endtask : t_mask
  task automatic t_tri();
    wr(`SCC_ADDR_TRISTATE, 8'h40);
    tick(2);
    chk("oe", {pix_data_oe_out, clk_out_oe_out}, 8'h02);
    wr(`SCC_ADDR_TRISTATE, 8'h80);
    tick(2);
    chk("oe", {pix_data_oe_out, clk_out_oe_out}, 8'h01);
    wr(`SCC_ADDR_TRISTATE, 8'hC0);
    $display("tristate done");
  endtask : t_tri
  task automatic t_pix();
    px(6'h00, 8'd100, 8'd131);
    wr(`SCC_ADDR_GAIN, 8'h00);
    px(6'h00, 8'd100, 8'd67);
    wr(`SCC_ADDR_GAIN, 8'h3F);
    px(6'h00, 8'd100, 8'd255);
    wr(`SCC_ADDR_GAIN, 8'h08);
    wr(`SCC_ADDR_BASE_OFS, 8'h0A);
    px(6'h00, 8'd80, 8'd131);
    wr(`SCC_ADDR_BASE_OFS, 8'h2A);
    px(6'h00, 8'd120, 8'd131);
    px(6'h00, 8'd10, 8'd0);
    wr(`SCC_ADDR_BASE_OFS, 8'h00);
    wr(`SCC_ADDR_FINAL_OFS, 8'h1F);
    px(6'h00, 8'd69, 8'd131);
    wr(`SCC_ADDR_FINAL_OFS, 8'h3F);
    px(6'h00, 8'd131, 8'd131);
    wr(`SCC_ADDR_FINAL_OFS, 8'h00);
    wr(`SCC_ADDR_COLPOS0, 8'h05);
    wr(`SCC_ADDR_COLPOS0 + 8'h03, 8'h3F);
    wr(`SCC_ADDR_TABLE0, 8'h05);
    wr(`SCC_ADDR_TABLE0 + 8'h03, 8'h0D);
    px(6'h05, 8'd100, 8'd131);
    wr(`SCC_ADDR_OFS_CTRL, 8'h01);
    px(6'h05, 8'd90, 8'd131);
    px(6'h3F, 8'd110, 8'd131);
    px(6'h3E, 8'd100, 8'd131);
    $display("pixel path done");
  endtask : t_pix
  task automatic t_gate();
    int n;
    for (int k = 0; k < 32; k++) begin
      wcap({2'h0, k[4:0], 1'b0});
      frame(1'b1);
    end
    wcap(8'h80);
    frame(1'b0);
    trig();
    frame(1'b1);
    frame(1'b0);
    wcap(8'h00);
    fstart(1'b1);
    wcap(8'h40);
    tick(4);
    chk("active", frame_active_out, 8'h01);
    fend();
    frame(1'b0);
    n = frames;
    trig();
    frame(1'b1);
    frame(1'b0);
    chk("frames", 8'(frames - n), 8'h01);
    wcap(8'h00);
    frame(1'b1);
    $display("capture modes done");
  endtask : t_gate
  task automatic t_rst();
    dark_level_in = 8'h10;
    wcap(8'h01);
    repeat (3) frame(1'b1);
    chk("clamp", dark_clamp_out, 8'h03);
    wcap(8'h00);
    repeat (2) frame(1'b1);
    chk("clamp", dark_clamp_out, 8'h03);
    wr(`SCC_ADDR_GAIN, 8'h15);
    wr(`SCC_ADDR_RESET, 8'h01);
    chk("clamp", dark_clamp_out, 8'h03);
    rdc(`SCC_ADDR_GAIN, 8'h08);
    wr(`SCC_ADDR_GAIN, 8'h20);
    rdc(`SCC_ADDR_GAIN, 8'h08);
    wr(`SCC_ADDR_RESET, 8'h02);
    tick(2);
    chk("clamp", dark_clamp_out, 8'h00);
    wr(`SCC_ADDR_GAIN, 8'h15);
    rdc(`SCC_ADDR_GAIN, 8'h15);
    wr(`SCC_ADDR_RESET, 8'h00);
    $display("block resets done");
  endtask : t_rst
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    rst_in = 1'b1;
    {mclk_in, reg_wr_in, reg_rd_in, fire, frame_start_in, frame_end_in, row_start_in} = 7'h00;
    {row_in_window_in, pix_valid_in, pix_in_window_in, pix_col_in} = 9'h000;
    {reg_addr_in, reg_wdata_in, pix_in, dark_level_in} = 32'h0000_0000;
    error_cnt = 0;
    checks_done = 0;
    cap = 8'hAA;
    tick(4);
    rst_in = 1'b0;
    t_regs();
    t_mask();
    t_tri();
    t_pix();
    t_gate();
    t_rst();
    conclude();
  end
  // Watchdog, over twenty times the expected run
  initial begin
    #60000;
    error_cnt++;
    conclude();
  end
endmodule : scc_sensor_ctrl_tb
